// *** rtl/mbs_slave.sv ***
/*
 Slave end: takes a six-byte query, reads inputs or registers, forces a coil
 and sends the response bytes.
 Assumes framing, the error check and scan timing are handled by the user side.
*/
// Behaviour
// (RQ1) Code 02 reads input states, never broadcast.
// (RQ2) Query: address, code, start, quantity, check.
// (RQ3) Input reads capped at 2000 or lower.
// (RQ4) Input addresses on the wire start at zero.
// (RQ5) One bit per input, first in LSB.
// (RQ6) Unused high bits of last byte zero.
// (RQ7) Byte count counts binary data bytes.
// (RQ8) Order: address, code, count, data, check.
// (RQ9) Data sampled at scan end, per-scan limit.
// (RQ10) Code 03 reads holding registers, max 125.
// (RQ11) Holding register addresses start at zero.
// (RQ12) Count byte, then registers high byte first.
// (RQ13) Code 04 reads input registers, max 125.
// (RQ14) Input register addresses start at zero.
// (RQ15) Input registers are read-only.
// (RQ16) FF00 sets coil, zero clears, others ignored.
// (RQ17) Coil addresses on the wire start at zero.
// (RQ18) Broadcast coil force is applied.
// (RQ19) Broadcast valid only for codes 5, 6, 15, 16.
// (RQ20) Coil force answer echoes the query.
// (RQ21) Coil force ignores any disable mark.
// (RQ22) Coils are not cleared at power-up.
// (RQ23) Bad quantity or range gives exception.
// (RQ24) Broadcast queries get no response.
`timescale 1ns/100ps
module mbs_slave
	import mbs_pkg::*;
#(
	parameter int N_IN = 64,
	parameter int N_HR = 16,
	parameter int N_IR = 16,
	parameter int N_COIL = 64,
	parameter int MAX_BITS = MBS_MAX_BITS,
	parameter int MAX_REGS = MBS_MAX_REGS
)(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	mbs_link_if.dev LINK,
	input wire logic [7:0] MY_ADDR,
	input wire logic SCAN_DONE,
	input wire logic [N_IN-1:0] DIN,
	input wire logic [N_HR*16-1:0] HREGS,
	input wire logic [N_IR*16-1:0] IREGS,
	output logic [N_COIL-1:0] COILS,
	output logic BUSY
);
	localparam int IW = $clog2(N_IN);
	localparam int HW = $clog2(N_HR);
	localparam int RW = $clog2(N_IR);
	localparam int CW = $clog2(N_COIL);

	generate
		if (MAX_BITS < 1 || MAX_BITS > MBS_MAX_BITS || MAX_REGS < 1 || MAX_REGS > MBS_MAX_REGS
			|| N_IN < 2 || N_HR < 2 || N_IR < 2 || N_COIL < 2 || N_IN > 65535
			|| N_HR > 65535 || N_IR > 65535 || N_COIL > 65535)
		begin : g_bad
			$error("mbs_slave: unsupported parameter values");
		end
	endgenerate

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_SEND = 3'b100
	} mbs_state_type;

	typedef enum logic [1:0] {
		TX_BITS = 2'h0,
		TX_REGS = 2'h1,
		TX_ECHO = 2'h2,
		TX_EXC = 2'h3
	} mbs_txmode_type;

	mbs_state_type state_ff;
	mbs_txmode_type tx_mode_ff;
	mbs_txmode_type nxt_mode;
	logic [7:0] rx_ff [0:5];
	logic [2:0] rx_cnt_ff;
	logic rx_ovf_ff;
	logic [N_IN-1:0] din_snap_ff;
	logic [15:0] hreg_snap_ff [0:N_HR-1];
	logic [15:0] ireg_snap_ff [0:N_IR-1];
	logic [N_COIL-1:0] coil_ff;
	logic use_hreg_ff;
	logic [8:0] tx_len_ff;
	logic [8:0] tx_idx_ff;
	logic [7:0] tx_bc_ff;
	logic [7:0] tx_exc_ff;
	logic [7:0] r_data_ff;
	logic r_valid_ff;
	logic r_last_ff;

	wire q_take = LINK.q_valid && LINK.q_ready;
	wire r_take = LINK.r_valid && LINK.r_ready;
	wire [7:0] fc = rx_ff[1];
	wire [15:0] start = {rx_ff[2], rx_ff[3]};
	wire [15:0] qty = {rx_ff[4], rx_ff[5]};
	wire [16:0] range_end = {1'b0, start} + {1'b0, qty};
	wire is_bcast = rx_ff[0] == MBS_BCAST_ADDR;
	wire is_mine = (rx_ff[0] == MY_ADDR) && !is_bcast;
	wire fc_bits = fc == MBS_FC_READ_INPUTS;
	wire fc_hreg = fc == MBS_FC_READ_HOLDING;
	wire fc_ireg = fc == MBS_FC_READ_INREGS;
	wire fc_coil = fc == MBS_FC_FORCE_COIL;
	wire [16:0] lim = fc_bits ? 17'(MAX_BITS) : 17'(MAX_REGS); // RQ3 RQ10 RQ13
	wire [16:0] space = fc_bits ? 17'(N_IN) : (fc_hreg ? 17'(N_HR) : 17'(N_IR));
	wire qty_bad = (qty == 16'h0000) || ({1'b0, qty} > lim); // RQ23
	wire range_bad = range_end > space; // RQ23
	wire val_on = qty == MBS_COIL_ON;
	wire val_ok = val_on || (qty == MBS_COIL_OFF); // RQ16
	wire coil_in = {1'b0, start} < 17'(N_COIL);
	wire [7:0] bc_bits = 8'((qty + 16'h0007) >> 3); // RQ6 RQ7
	wire [7:0] bc_regs = 8'({qty, 1'b0}); // RQ7 RQ12
	// Broadcast reads and broadcast unknown codes fall through here and are dropped.
	wire do_force = fc_coil && val_ok && coil_in && (is_mine || is_bcast); // RQ16 RQ18 RQ19 RQ21
	wire do_reply = is_mine; // RQ1 RQ19 RQ24

	logic [7:0] exc_code;
	always_comb
	begin
		exc_code = 8'h00;
		nxt_mode = TX_EXC;
		if (fc_bits || fc_hreg || fc_ireg)
		begin
			if (qty_bad)
				exc_code = MBS_EXC_VALUE;
			else if (range_bad)
				exc_code = MBS_EXC_ADDR;
			else
				nxt_mode = fc_bits ? TX_BITS : TX_REGS;
		end
		else if (fc_coil)
		begin
			if (!val_ok)
				exc_code = MBS_EXC_VALUE;
			else if (!coil_in)
				exc_code = MBS_EXC_ADDR;
			else
				nxt_mode = TX_ECHO; // RQ20
		end
		else
			exc_code = MBS_EXC_FUNC;
	end

	wire [8:0] nxt_len = (nxt_mode == TX_EXC) ? MBS_HDR_LEN :
		(nxt_mode == TX_ECHO) ? MBS_ECHO_LEN :
		MBS_HDR_LEN + {1'b0, (nxt_mode == TX_BITS) ? bc_bits : bc_regs};

	// Byte picked for the next send position.
	wire [8:0] sel_idx = tx_idx_ff + 9'h001;
	wire [7:0] k = 8'(sel_idx - MBS_HDR_LEN);
	logic [7:0] bits_byte;
	genvar j;
	generate
		for (j = 0; j < 8; j++)
		begin : g_bit
			wire [15:0] pos = {5'h00, k, 3'(j)};
			wire [16:0] adr = {1'b0, start} + {1'b0, pos};
			assign bits_byte[j] = (pos < qty) && (adr < 17'(N_IN))
				&& din_snap_ff[adr[IW-1:0]]; // RQ4 RQ5 RQ6
		end
	endgenerate
	wire [16:0] reg_adr = {1'b0, start} + {10'h000, k[7:1]}; // RQ11 RQ14
	wire [15:0] hword = (reg_adr < 17'(N_HR)) ? hreg_snap_ff[reg_adr[HW-1:0]] : 16'h0000;
	wire [15:0] iword = (reg_adr < 17'(N_IR)) ? ireg_snap_ff[reg_adr[RW-1:0]] : 16'h0000;
	wire [15:0] rword = use_hreg_ff ? hword : iword;
	wire [7:0] regs_byte = k[0] ? rword[7:0] : rword[15:8]; // RQ12
	wire [7:0] echo_byte = (sel_idx < MBS_ECHO_LEN) ? rx_ff[sel_idx[2:0]] : 8'h00;
	wire [7:0] data_byte = (tx_mode_ff == TX_BITS) ? bits_byte : regs_byte;
	wire [7:0] nxt_byte = (tx_mode_ff == TX_ECHO) ? echo_byte : // RQ20
		(sel_idx == 9'h001) ? ((tx_mode_ff == TX_EXC) ? (fc | MBS_FC_EXC_FLAG) : fc) :
		(sel_idx == 9'h002) ? ((tx_mode_ff == TX_EXC) ? tx_exc_ff : tx_bc_ff) :
		data_byte; // RQ8

	assign LINK.q_ready = CE && (state_ff == ST_IDLE);
	assign LINK.r_valid = CE && r_valid_ff;
	assign LINK.r_data = r_data_ff;
	assign LINK.r_last = r_last_ff;
	assign COILS = coil_ff;
	assign BUSY = state_ff != ST_IDLE;

	// Snapshot only between queries so one response never mixes two scans.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			din_snap_ff <= '0;
			for (int i = 0; i < N_HR; i++)
				hreg_snap_ff[i] <= MBS_RESET_WORD;
			for (int i = 0; i < N_IR; i++)
				ireg_snap_ff[i] <= MBS_RESET_WORD;
		end
		else if (CE && SCAN_DONE && state_ff == ST_IDLE) // RQ9
		begin
			din_snap_ff <= DIN;
			for (int i = 0; i < N_HR; i++)
				hreg_snap_ff[i] <= HREGS[i*16 +: 16];
			for (int i = 0; i < N_IR; i++)
				ireg_snap_ff[i] <= IREGS[i*16 +: 16]; // RQ15
		end
	end

	// Coils keep their state through reset on purpose.
	always_ff @(posedge CLK)
	begin
		if (CE && state_ff == ST_EXEC && do_force)
			coil_ff[start[CW-1:0]] <= val_on; // RQ17 RQ22
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			for (int i = 0; i < 6; i++)
				rx_ff[i] <= MBS_RESET_BYTE;
			rx_cnt_ff <= 3'h0;
			rx_ovf_ff <= 1'b0;
		end
		else if (CE && q_take)
		begin
			if (!rx_ovf_ff)
				rx_ff[rx_cnt_ff] <= LINK.q_data; // RQ2
			rx_cnt_ff <= LINK.q_last ? 3'h0 : (rx_cnt_ff == MBS_QUERY_LAST ? 3'h0 : rx_cnt_ff + 3'h1);
			rx_ovf_ff <= LINK.q_last ? 1'b0 : (rx_ovf_ff || rx_cnt_ff == MBS_QUERY_LAST);
		end
	end

	wire frame_ok = LINK.q_last && !rx_ovf_ff && rx_cnt_ff == MBS_QUERY_LAST;

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_ff <= ST_IDLE;
			tx_mode_ff <= TX_EXC;
			use_hreg_ff <= 1'b0;
			tx_len_ff <= 9'h000;
			tx_idx_ff <= 9'h000;
			tx_bc_ff <= 8'h00;
			tx_exc_ff <= 8'h00;
			r_data_ff <= 8'h00;
			r_valid_ff <= 1'b0;
			r_last_ff <= 1'b0;
		end
		else if (CE)
		begin
			case (state_ff)
				ST_IDLE:
					if (q_take && frame_ok)
						state_ff <= ST_EXEC;
				ST_EXEC:
				begin
					tx_mode_ff <= nxt_mode;
					use_hreg_ff <= fc_hreg;
					tx_len_ff <= nxt_len;
					tx_bc_ff <= fc_bits ? bc_bits : bc_regs;
					tx_exc_ff <= exc_code;
					tx_idx_ff <= 9'h000;
					r_data_ff <= rx_ff[0];
					r_valid_ff <= do_reply;
					r_last_ff <= 1'b0;
					state_ff <= do_reply ? ST_SEND : ST_IDLE; // RQ24
				end
				ST_SEND:
					if (r_take)
					begin
						if (r_last_ff)
						begin
							r_valid_ff <= 1'b0;
							r_last_ff <= 1'b0;
							state_ff <= ST_IDLE;
						end
						else
						begin
							tx_idx_ff <= sel_idx;
							r_data_ff <= nxt_byte;
							r_last_ff <= sel_idx == tx_len_ff - 9'h001;
						end
					end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule

// *** common/mbs_pkg.sv ***
/*
 Shared constants for the serial-link query handler: function codes, limits,
 frame layout and exception codes.
 Assumes framing and the error check are stripped and added outside both ends.
*/
package mbs_pkg;
	localparam logic [7:0] MBS_BCAST_ADDR = 8'h00;
	localparam logic [7:0] MBS_FC_READ_INPUTS = 8'h02;
	localparam logic [7:0] MBS_FC_READ_HOLDING = 8'h03;
	localparam logic [7:0] MBS_FC_READ_INREGS = 8'h04;
	localparam logic [7:0] MBS_FC_FORCE_COIL = 8'h05;
	localparam logic [7:0] MBS_FC_EXC_FLAG = 8'h80;
	localparam logic [15:0] MBS_COIL_ON = 16'hFF00;
	localparam logic [15:0] MBS_COIL_OFF = 16'h0000;
	localparam logic [7:0] MBS_EXC_FUNC = 8'h01;
	localparam logic [7:0] MBS_EXC_ADDR = 8'h02;
	localparam logic [7:0] MBS_EXC_VALUE = 8'h03;
	localparam int MBS_MAX_BITS = 2000;
	localparam int MBS_MAX_REGS = 125;
	localparam logic [2:0] MBS_QUERY_LAST = 3'h5;
	localparam logic [8:0] MBS_HDR_LEN = 9'h003;
	localparam logic [8:0] MBS_ECHO_LEN = 9'h006;
	localparam logic [7:0] MBS_RESET_BYTE = 8'h00;
	localparam logic [15:0] MBS_RESET_WORD = 16'h0000;
endpackage

// *** common/mbs_link_if.sv ***
/*
 Byte link between the query master and the slave handler.
 Assumes one shared clock; each byte moves when valid and ready are both high.
*/
`timescale 1ns/100ps
interface mbs_link_if;
	logic q_valid;
	logic q_ready;
	logic [7:0] q_data;
	logic q_last;
	logic r_valid;
	logic r_ready;
	logic [7:0] r_data;
	logic r_last;
	modport dev (input q_valid, output q_ready, input q_data, input q_last,
		output r_valid, input r_ready, output r_data, output r_last);
	modport mst (output q_valid, input q_ready, output q_data, output q_last,
		input r_valid, output r_ready, input r_data, input r_last);
endinterface

// *** rtl/mbs_master.sv ***
/*
 Master end: sends six-byte queries and passes response bytes to the user.
 Assumes the user side waits for CMD_READY and sinks a response byte a cycle.
*/
`timescale 1ns/100ps
module mbs_master
	import mbs_pkg::*;
#(
	parameter int MAX_BITS = MBS_MAX_BITS,
	parameter int MAX_REGS = MBS_MAX_REGS
)(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	mbs_link_if.mst LINK,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire logic [7:0] CMD_SLAVE,
	input wire logic [7:0] CMD_FUNC,
	input wire logic [15:0] CMD_START,
	input wire logic [15:0] CMD_ARG,
	output logic CMD_REJECT,
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA,
	output logic RSP_LAST
);
	generate
		if (MAX_BITS < 1 || MAX_BITS > MBS_MAX_BITS || MAX_REGS < 1 || MAX_REGS > MBS_MAX_REGS)
		begin : g_bad
			$error("mbs_master: unsupported limits");
		end
	endgenerate

	typedef enum logic [1:0] {
		MS_IDLE = 2'b01,
		MS_SEND = 2'b10
	} mbs_mstate_type;

	mbs_mstate_type state_ff;
	logic [47:0] shreg_ff;
	logic [2:0] cnt_ff;
	logic reject_ff;
	logic rsp_valid_ff;
	logic [7:0] rsp_data_ff;
	logic rsp_last_ff;

	wire is_read = (CMD_FUNC == MBS_FC_READ_INPUTS) || (CMD_FUNC == MBS_FC_READ_HOLDING)
		|| (CMD_FUNC == MBS_FC_READ_INREGS);
	wire [15:0] lim = (CMD_FUNC == MBS_FC_READ_INPUTS) ? 16'(MAX_BITS) : 16'(MAX_REGS);
	// Reads are never broadcast and never exceed this end's MAX_BITS or MAX_REGS limit.
	wire refuse = is_read && (CMD_SLAVE == MBS_BCAST_ADDR || CMD_ARG == 16'h0000
		|| CMD_ARG > lim); // RQ3 RQ10 RQ13
	wire cmd_take = CMD_VALID && CMD_READY;
	wire q_take = LINK.q_valid && LINK.q_ready;

	assign CMD_READY = CE && (state_ff == MS_IDLE);
	assign LINK.q_valid = CE && (state_ff == MS_SEND);
	assign LINK.q_data = shreg_ff[47:40];
	assign LINK.q_last = cnt_ff == MBS_QUERY_LAST;
	assign LINK.r_ready = CE;
	assign CMD_REJECT = reject_ff;
	assign RSP_VALID = rsp_valid_ff;
	assign RSP_DATA = rsp_data_ff;
	assign RSP_LAST = rsp_last_ff;

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_ff <= MS_IDLE;
			shreg_ff <= '0;
			cnt_ff <= 3'h0;
			reject_ff <= 1'b0;
		end
		else if (CE)
		begin
			reject_ff <= cmd_take && refuse;
			case (state_ff)
				MS_IDLE:
					if (cmd_take && !refuse)
					begin
						shreg_ff <= {CMD_SLAVE, CMD_FUNC, CMD_START, CMD_ARG}; // RQ2
						cnt_ff <= 3'h0;
						state_ff <= MS_SEND;
					end
				MS_SEND:
					if (q_take)
					begin
						shreg_ff <= {shreg_ff[39:0], 8'h00};
						cnt_ff <= cnt_ff + 3'h1;
						if (LINK.q_last)
							state_ff <= MS_IDLE;
					end
				default:
					state_ff <= MS_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= 8'h00;
			rsp_last_ff <= 1'b0;
		end
		else if (CE)
		begin
			rsp_valid_ff <= LINK.r_valid;
			rsp_data_ff <= LINK.r_data;
			rsp_last_ff <= LINK.r_valid && LINK.r_last;
		end
	end
endmodule

// *** sim/mbs_link_monitor.sv ***
/*
 Checker for the byte link joining master and slave ends.
 Assumes one shared clock and that only own or broadcast addresses are used.
*/
`timescale 1ns/100ps
module mbs_link_monitor
	import mbs_pkg::*;
#(
	parameter int N_COIL = 64
)(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic q_valid,
	input wire logic q_ready,
	input wire logic [7:0] q_data,
	input wire logic q_last,
	input wire logic r_valid,
	input wire logic r_ready,
	input wire logic [7:0] r_data,
	input wire logic r_last
);
	logic [7:0] qb_ff [6];
	logic [2:0] qn_ff;
	logic [8:0] rn_ff;
	logic exc_ff;
	wire logic q_take = q_valid && q_ready;
	wire logic r_take = r_valid && r_ready;
	wire logic [7:0] fn = qb_ff[1];
	wire logic [15:0] qty = {qb_ff[4], qb_ff[5]};
	wire logic rd = fn inside {MBS_FC_READ_INPUTS, MBS_FC_READ_HOLDING, MBS_FC_READ_INREGS};
	wire logic [7:0] cnt = (fn == MBS_FC_READ_INPUTS) ? 8'((qty + 16'h0007) >> 3) : 8'(qty << 1);
	// Query bytes need no reset: they are only looked at after a whole frame.
	always_ff @(posedge CLK)
	begin
		if (q_take)
			qb_ff[qn_ff] <= q_data;
	end
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			qn_ff <= 3'h0;
			rn_ff <= 9'h000;
			exc_ff <= 1'b0;
		end
		else
		begin
			if (q_take)
				qn_ff <= q_last ? 3'h0 : qn_ff + 3'h1;
			if (r_take)
				rn_ff <= r_last ? 9'h000 : rn_ff + 9'h001;
			if (r_take && rn_ff == 9'h001)
				exc_ff <= r_data[7];
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	property p_q_hold;
		q_valid && !q_ready |=> q_valid && $stable(q_data) && $stable(q_last);
	endproperty
	a_q_hold: assert property (p_q_hold) else $error("query byte changed");
	property p_r_hold;
		r_valid && !r_ready |=> r_valid && $stable(r_data) && $stable(r_last);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("response byte changed");
	property p_answer;
		q_take && q_last && qb_ff[0] != MBS_BCAST_ADDR |-> ##[1:4] r_valid;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_bcast;
		q_take && q_last && qb_ff[0] == MBS_BCAST_ADDR |=> !r_valid [*8];
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast answered");
	property p_first;
		r_valid && rn_ff == 9'h000 |-> r_data == qb_ff[0];
	endproperty
	a_first: assert property (p_first) else $error("bad first byte");
	property p_echo;
		r_valid && fn == MBS_FC_FORCE_COIL && (qty == MBS_COIL_ON || qty == MBS_COIL_OFF)
			&& {qb_ff[2], qb_ff[3]} < 16'(N_COIL) && rn_ff < 9'h006
			|-> r_data == qb_ff[rn_ff[2:0]] && r_last == (rn_ff == 9'h005);
	endproperty
	a_echo: assert property (p_echo) else $error("bad echo");
	property p_count;
		r_valid && rn_ff == 9'h002 && !exc_ff && rd |-> r_data == cnt;
	endproperty
	a_count: assert property (p_count) else $error("bad byte count");
	property p_exc;
		r_valid && rn_ff == 9'h002 && exc_ff |-> r_last;
	endproperty
	a_exc: assert property (p_exc) else $error("bad exception length");
endmodule

// *** sim/mbs_handler_tb.sv ***
/*
 Testbench joining master and slave ends over one link.
 Assumes package, link interface and both ends are compiled first.
*/
`timescale 1ns/100ps
module mbs_handler_tb
	import mbs_pkg::*;
;
	logic CLK = 1'b0;
	logic RSTN = 1'b0;
	logic cmd_valid = 1'b0;
	logic scan_done = 1'b0;
	logic rej;
	logic seen_last;
	logic slave_ce = 1'b1;
	logic [7:0] my_addr = 8'h11;
	logic [7:0] cmd_slave = 8'h00;
	logic [7:0] cmd_func = 8'h00;
	logic [15:0] cmd_start = 16'h0000;
	logic [15:0] cmd_arg = 16'h0000;
	logic [63:0] din = 64'h5A3C_E187_0FF0_96C3;
	logic [255:0] hregs;
	logic [255:0] iregs;
	logic cmd_ready, cmd_reject, rsp_valid, rsp_last, busy;
	logic [7:0] rsp_data;
	logic [63:0] coils;
	logic [7:0] got[$];
	logic [7:0] exp[$];
	int err_count = 0;
	int check_count = 0;
	mbs_link_if link();
	always #2 CLK = ~CLK;
	// The slave gets a lower input limit than the master, so its own refusal is reachable.
	mbs_slave #(.MAX_BITS(32)) mbs_slave_i (.CLK(CLK), .RSTN(RSTN), .CE(slave_ce),
		.LINK(link.dev), .MY_ADDR(my_addr), .SCAN_DONE(scan_done), .DIN(din),
		.HREGS(hregs), .IREGS(iregs), .COILS(coils), .BUSY(busy));
	mbs_master mbs_master_i (.CLK(CLK), .RSTN(RSTN), .CE(1'b1), .LINK(link.mst),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_SLAVE(cmd_slave),
		.CMD_FUNC(cmd_func), .CMD_START(cmd_start), .CMD_ARG(cmd_arg),
		.CMD_REJECT(cmd_reject), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
		.RSP_LAST(rsp_last));
	mbs_link_monitor #(.N_COIL(64)) mbs_link_monitor_i (.CLK(CLK), .RSTN(RSTN),
		.q_valid(link.q_valid), .q_ready(link.q_ready), .q_data(link.q_data),
		.q_last(link.q_last), .r_valid(link.r_valid), .r_ready(link.r_ready),
		.r_data(link.r_data), .r_last(link.r_last));
	task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic check1(input string what, input logic e, input logic g);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic scan();
		scan_done <= 1'b1;
		@(posedge CLK);
		scan_done <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic query(input logic [7:0] sl, input logic [7:0] fc,
		input logic [15:0] st, input logic [15:0] ar);
		got.delete();
		seen_last = 1'b0;
		{cmd_slave, cmd_func, cmd_start, cmd_arg} <= {sl, fc, st, ar};
		cmd_valid <= 1'b1;
		#1;
		wait (cmd_ready === 1'b1);
		@(posedge CLK);
		cmd_valid <= 1'b0;
		// The refusal pulse stands only in the cycle right after the take.
		@(negedge CLK);
		rej = cmd_reject;
		repeat (60)
		begin
			@(negedge CLK);
			if (rsp_valid === 1'b1)
				got.push_back(rsp_data);
			if (rsp_valid === 1'b1 && rsp_last === 1'b1)
			begin
				seen_last = 1'b1;
				break;
			end
		end
		@(posedge CLK);
	endtask
	task automatic check_rsp();
		check8("length", 8'(exp.size()), 8'(got.size()));
		check1("last", exp.size() != 0, seen_last);
		foreach (exp[i])
			check8("byte", exp[i], got[i]);
	endtask
	task automatic add_regs(input logic [255:0] r, input int st, input int n);
		for (int i = st; i < st + n; i++)
		begin
			exp.push_back(r[16*i+8+:8]);
			exp.push_back(r[16*i+:8]);
		end
	endtask
	initial
	begin
		for (int i = 0; i < 16; i++)
		begin
			hregs[16*i+:16] = {8'(i), 8'(8'hF0 - i)};
			iregs[16*i+:16] = {8'(8'h80 + i), 8'(3 * i)};
		end
		repeat (4) @(posedge CLK);
		RSTN <= 1'b1;
		scan();
		query(8'h11, MBS_FC_READ_INPUTS, 16'h0003, 16'h000D);
		exp = {8'h11, 8'h02, 8'h02, din[10:3], 8'(din[15:11])};
		check_rsp();
		check1("refused", 1'b0, rej);
		query(8'h11, MBS_FC_READ_INPUTS, 16'h0000, 16'h0020);
		exp = {8'h11, 8'h02, 8'h04, din[7:0], din[15:8], din[23:16], din[31:24]};
		check_rsp();
		query(8'h11, MBS_FC_READ_INPUTS, 16'h0000, 16'h0021);
		exp = {8'h11, 8'h82, MBS_EXC_VALUE};
		check_rsp();
		query(8'h11, MBS_FC_READ_INPUTS, 16'h003C, 16'h0008);
		exp = {8'h11, 8'h82, MBS_EXC_ADDR};
		check_rsp();
		din <= ~din;
		query(8'h11, MBS_FC_READ_INPUTS, 16'h0000, 16'h0008);
		exp = {8'h11, 8'h02, 8'h01, ~din[7:0]};
		check_rsp();
		scan();
		query(8'h11, MBS_FC_READ_INPUTS, 16'h0000, 16'h0008);
		exp = {8'h11, 8'h02, 8'h01, din[7:0]};
		check_rsp();
		query(8'h11, MBS_FC_READ_HOLDING, 16'h0002, 16'h0003);
		exp = {8'h11, 8'h03, 8'h06};
		add_regs(hregs, 2, 3);
		check_rsp();
		query(8'h11, MBS_FC_READ_INREGS, 16'h000F, 16'h0001);
		exp = {8'h11, 8'h04, 8'h02};
		add_regs(iregs, 15, 1);
		check_rsp();
		query(8'h11, MBS_FC_READ_INREGS, 16'h000F, 16'h0002);
		exp = {8'h11, 8'h84, MBS_EXC_ADDR};
		check_rsp();
		query(8'h11, MBS_FC_FORCE_COIL, 16'h0005, MBS_COIL_OFF);
		exp = {8'h11, 8'h05, 8'h00, 8'h05, 8'h00, 8'h00};
		check_rsp();
		check1("coil", 1'b0, coils[5]);
		query(8'h11, MBS_FC_FORCE_COIL, 16'h0005, MBS_COIL_ON);
		exp = {8'h11, 8'h05, 8'h00, 8'h05, 8'hFF, 8'h00};
		check_rsp();
		check1("coil", 1'b1, coils[5]);
		query(8'h11, MBS_FC_FORCE_COIL, 16'h0005, 16'h1234);
		exp = {8'h11, 8'h85, MBS_EXC_VALUE};
		check_rsp();
		check1("coil", 1'b1, coils[5]);
		query(MBS_BCAST_ADDR, MBS_FC_FORCE_COIL, 16'h0007, MBS_COIL_ON);
		exp.delete();
		check_rsp();
		check1("coil", 1'b1, coils[7]);
		for (int f = 2; f < 5; f++)
		begin
			query(MBS_BCAST_ADDR, 8'(f), 16'h0000, 16'h0001);
			check1("refused", 1'b1, rej);
			check_rsp();
		end
		query(MBS_BCAST_ADDR, 8'h01, 16'h0000, 16'h0001);
		exp.delete();
		check1("refused", 1'b0, rej);
		check_rsp();
		query(8'h11, 8'h06, 16'h0001, 16'h0003);
		exp = {8'h11, 8'h86, MBS_EXC_FUNC};
		check_rsp();
		query(8'h11, MBS_FC_FORCE_COIL, 16'h0040, MBS_COIL_ON);
		exp = {8'h11, 8'h85, MBS_EXC_ADDR};
		check_rsp();
		// Pausing the slave in mid-query makes the master hold its byte on the link.
		fork
			query(8'h11, MBS_FC_READ_HOLDING, 16'h0000, 16'h0003);
			begin
				repeat (3) @(posedge CLK);
				slave_ce <= 1'b0;
				repeat (3) @(posedge CLK);
				slave_ce <= 1'b1;
				repeat (6) @(posedge CLK);
				@(negedge CLK);
				check1("busy", 1'b1, busy);
			end
		join
		exp = {8'h11, 8'h03, 8'h06};
		add_regs(hregs, 0, 3);
		check_rsp();
		RSTN <= 1'b0;
		repeat (4) @(posedge CLK);
		RSTN <= 1'b1;
		check1("coil", 1'b1, coils[5]);
		check1("busy", 1'b0, busy);
		@(posedge CLK);
		complete_run();
	end
	initial
	begin
		repeat (4000) @(posedge CLK);
		err_count++;
		complete_run();
	end
endmodule
